// *** core/cise_core.sv ***
// execution core for a subset of instructions of an 8-bit controller
// assumes the sequencer issues one instruction per cycle on sys_clk, holds off while busy,
// and returns file register contents combinationally for the issued address
//
// What this block does
// RULE_01: file minus accumulator, flags, destination select
// RULE_02: swap nibbles of file, flags untouched
// RULE_03: immediate minus accumulator into accumulator, one cycle
// RULE_04: table address from pointer and accumulator
// RULE_05: table upper six bits to data, two cycles
// RULE_06: accumulator loads timer0 mode register, one cycle
// RULE_07: timer0 mode register read into accumulator
// RULE_08: xor file with accumulator, zero only
// RULE_09: xor immediate with accumulator, zero only
// RULE_10: carry and half carry mean no borrow
// RULE_11: zero flag set on zero result
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "cise_defs.svh"
module cise_core (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire cise_pkg::cise_instr_t instr,
    input wire logic [7:0] file_rdata,
    input wire logic [2:0] table_high_pointer,
    input wire logic [`CISE_ROM_W-1:0] rom_rdata,
    input wire cise_pkg::cise_flags_t flags_in,
    output logic [7:0] acc,
    output logic [7:0] timer0_mode_register,
    output logic [5:0] table_high_data,
    output cise_pkg::cise_flags_t flags,
    output logic [`CISE_ROM_ADDR_W-1:0] rom_addr,
    output logic rom_rd,
    output logic file_we,
    output logic [`CISE_FADDR_W-1:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic busy
);
    import cise_pkg::*;

    // ----------------------------------------
    // arithmetic
    // ----------------------------------------
    // subtraction as a + ~acc + 1: carry out is the no-borrow flag
    wire logic is_sub_file = instr.op == CISE_OP_SUB_FILE;
    wire logic is_sub_imm = instr.op == CISE_OP_SUB_IMM;
    wire logic is_xor_file = instr.op == CISE_OP_XOR_FILE;
    wire logic is_xor_imm = instr.op == CISE_OP_XOR_IMM;
    wire logic is_swap = instr.op == CISE_OP_SWAP;
    wire logic [7:0] minuend = is_sub_imm ? instr.operand : file_rdata;
    wire logic [8:0] diff = {1'b0, minuend} + {1'b0, ~acc} + 9'h001; // RULE_01 RULE_03
    wire logic [4:0] diff_lo = {1'b0, minuend[`CISE_HALF_LO:0]} + {1'b0, ~acc[`CISE_HALF_LO:0]} + 5'h01;
    wire logic [7:0] xor_src = is_xor_imm ? instr.operand : file_rdata;
    wire logic [7:0] xor_res = acc ^ xor_src; // RULE_08 RULE_09
    // nibble halves trade places; the flags bypass this path entirely
    wire logic [7:0] swap_res = {file_rdata[`CISE_HALF_LO:0], file_rdata[`CISE_BYTE_HI:`CISE_NIB_HI_LO]}; // RULE_02
    wire logic is_sub = is_sub_file | is_sub_imm;
    wire logic is_xor = is_xor_file | is_xor_imm;
    wire logic [7:0] alu_res = is_sub ? diff[7:0] : (is_xor ? xor_res : swap_res);
    wire logic alu_op = is_sub | is_xor | is_swap;
    wire logic to_file = (is_sub_file | is_xor_file | is_swap) & instr.dest_sel;
    wire logic res_zero = alu_res == `CISE_ZERO8; // RULE_11

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    cise_state_t state;
    cise_state_t next_state;
    // an instruction is taken only from idle; while busy it is ignored, not queued
    wire logic go = clk_en & instr_valid & (state == CISE_ST_IDLE);

    always_comb begin
        case (state)
            CISE_ST_IDLE: next_state = (go && instr.op == CISE_OP_TABLE) ? CISE_ST_TABLE : CISE_ST_IDLE;
            CISE_ST_TABLE: next_state = CISE_ST_IDLE; // RULE_05
            default: next_state = CISE_ST_IDLE;
        endcase
    end

    // flags start from the caller's status so that untouched bits pass through
    cise_flags_t next_flags;
    always_comb begin
        next_flags = flags_in;
        if (is_sub) begin
            next_flags.carry = diff[8]; // RULE_10
            next_flags.half_carry_flag = diff_lo[4]; // RULE_10
        end
        if (is_sub | is_xor) begin
            next_flags.zero = res_zero; // RULE_11
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= CISE_ST_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= `CISE_ACC_RST;
            timer0_mode_register <= `CISE_TIMER0_MODE_REGISTER_RST;
            table_high_data <= `CISE_TABLE_HIGH_DATA_RST;
            flags <= '0;
            rom_addr <= '0;
            rom_rd <= 1'b0;
            file_we <= 1'b0;
            file_waddr <= '0;
            file_wdata <= `CISE_ZERO8;
            busy <= 1'b0;
        end else if (clk_en) begin
            file_we <= 1'b0;
            rom_rd <= 1'b0;
            busy <= go && instr.op == CISE_OP_TABLE;
            if (go) begin
                flags <= next_flags;
                if (alu_op && !to_file) begin
                    acc <= alu_res; // RULE_01 RULE_02 RULE_03 RULE_08 RULE_09
                end
                if (alu_op && to_file) begin
                    file_we <= 1'b1; // RULE_01 RULE_02 RULE_08
                    file_waddr <= instr.faddr;
                    file_wdata <= alu_res;
                end
                if (instr.op == CISE_OP_TIMER0_MODE_REGISTER_LD) begin
                    timer0_mode_register <= acc; // RULE_06
                end
                if (instr.op == CISE_OP_TIMER0_MODE_REGISTER_RD) begin
                    acc <= timer0_mode_register; // RULE_07
                end
                if (instr.op == CISE_OP_TABLE) begin
                    // pointer sampled at issue; later pointer changes cannot move the fetch
                    rom_addr <= {table_high_pointer[`CISE_TABLE_HIGH_POINTER_LO:0], acc}; // RULE_04
                    rom_rd <= 1'b1;
                end
            end
            // the rom word lands in the second cycle, while go is held off
            if (state == CISE_ST_TABLE) begin
                acc <= rom_rdata[`CISE_ROM_LO_HI:0]; // RULE_04
                table_high_data <= rom_rdata[`CISE_ROM_HI:`CISE_ROM_LO_HI+1]; // RULE_05
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_sub_imm;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_sub_imm |=> !file_we && acc == $past(instr.operand) - $past(acc);
    endproperty
    a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong"); // RULE_03

    property p_sub_file_dest;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_sub_file && instr.dest_sel |=> file_we && acc == $past(acc)
            && file_waddr == $past(instr.faddr)
            && file_wdata == $past(file_rdata) - $past(acc);
    endproperty
    a_sub_file_dest: assert property (p_sub_file_dest) else $error("file subtract wrong"); // RULE_01

    property p_sub_file_acc;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_sub_file && !instr.dest_sel |=> !file_we
            && acc == $past(file_rdata) - $past(acc);
    endproperty
    a_sub_file_acc: assert property (p_sub_file_acc) else $error("file subtract to acc wrong"); // RULE_01

    // carry and half carry read as no borrow, so equal operands set both
    property p_carry;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_sub |=> flags.carry == ($past(minuend) >= $past(acc));
    endproperty
    a_carry: assert property (p_carry) else $error("carry not no-borrow"); // RULE_10

    property p_half;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_sub |=> flags.half_carry_flag
            == ($past(minuend[`CISE_HALF_LO:0]) >= $past(acc[`CISE_HALF_LO:0]));
    endproperty
    a_half: assert property (p_half) else $error("half carry not no-borrow"); // RULE_10

    property p_sub_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_sub |=> flags.zero == ($past(minuend) == $past(acc));
    endproperty
    a_sub_zero: assert property (p_sub_zero) else $error("subtract zero flag wrong"); // RULE_11

    // ----------------------------------------
    // checks: swap and exclusive or
    // ----------------------------------------
    property p_swap;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_swap && !instr.dest_sel |=> !file_we && acc == {$past(file_rdata[`CISE_HALF_LO:0]),
            $past(file_rdata[`CISE_BYTE_HI:`CISE_NIB_HI_LO])} && flags == $past(flags_in);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong"); // RULE_02

    property p_swap_file;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_swap && instr.dest_sel |=> file_we && acc == $past(acc) && flags == $past(flags_in)
            && file_wdata == {$past(file_rdata[`CISE_HALF_LO:0]), $past(file_rdata[`CISE_BYTE_HI:`CISE_NIB_HI_LO])};
    endproperty
    a_swap_file: assert property (p_swap_file) else $error("swap to file wrong"); // RULE_02

    property p_xor_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_xor |=> flags.zero == ($past(acc) == $past(xor_src))
            && flags.carry == $past(flags_in.carry);
    endproperty
    a_xor_zero: assert property (p_xor_zero) else $error("xor flags wrong"); // RULE_08 RULE_09 RULE_11

    property p_xor_half;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_xor |=> flags.half_carry_flag == $past(flags_in.half_carry_flag);
    endproperty
    a_xor_half: assert property (p_xor_half) else $error("xor touched half carry"); // RULE_08 RULE_09

    property p_xor_imm_acc;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_xor_imm |=> !file_we && acc == ($past(acc) ^ $past(instr.operand));
    endproperty
    a_xor_imm_acc: assert property (p_xor_imm_acc) else $error("xor immediate result wrong"); // RULE_09

    property p_xor_file_acc;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_xor_file && !instr.dest_sel |=> !file_we && acc == ($past(acc) ^ $past(file_rdata));
    endproperty
    a_xor_file_acc: assert property (p_xor_file_acc) else $error("xor file to acc wrong"); // RULE_08

    property p_xor_file;
        @(posedge sys_clk) disable iff (sys_rst)
        go && is_xor_file && instr.dest_sel |=> file_we && acc == $past(acc)
            && file_waddr == $past(instr.faddr) && file_wdata == ($past(acc) ^ $past(file_rdata));
    endproperty
    a_xor_file: assert property (p_xor_file) else $error("xor to file wrong"); // RULE_08

    // ----------------------------------------
    // checks: table read
    // ----------------------------------------
    property p_table_addr;
        @(posedge sys_clk) disable iff (sys_rst)
        go && instr.op == CISE_OP_TABLE |=> rom_rd && busy
            && rom_addr == {$past(table_high_pointer), $past(acc)};
    endproperty
    a_table_addr: assert property (p_table_addr) else $error("table address wrong"); // RULE_04

    property p_table;
        @(posedge sys_clk) disable iff (sys_rst)
        go && instr.op == CISE_OP_TABLE && clk_en ##1 clk_en |=> acc == $past(rom_rdata[`CISE_ROM_LO_HI:0])
            && table_high_data == $past(rom_rdata[`CISE_ROM_HI:`CISE_ROM_LO_HI+1]) && $past(busy);
    endproperty
    a_table: assert property (p_table) else $error("table read wrong"); // RULE_04 RULE_05

    // an instruction offered during the busy cycle must leave no trace
    property p_busy_refuse;
        @(posedge sys_clk) disable iff (sys_rst)
        busy && clk_en |=> !busy && !rom_rd && !file_we && flags == $past(flags);
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("instruction taken while busy"); // RULE_05

    property p_rom_rd_pulse;
        @(posedge sys_clk) disable iff (sys_rst)
        rom_rd && clk_en |=> !rom_rd;
    endproperty
    a_rom_rd_pulse: assert property (p_rom_rd_pulse) else $error("rom read strobe too long"); // RULE_05

    // ----------------------------------------
    // checks: timer0 mode register and clock enable
    // ----------------------------------------
    property p_timer0_mode_register;
        @(posedge sys_clk) disable iff (sys_rst)
        go && instr.op == CISE_OP_TIMER0_MODE_REGISTER_LD |=> timer0_mode_register == $past(acc)
            && flags == $past(flags_in);
    endproperty
    a_timer0_mode_register: assert property (p_timer0_mode_register) else $error("mode load wrong"); // RULE_06

    property p_timer0_mode_register_acc;
        @(posedge sys_clk) disable iff (sys_rst)
        go && instr.op == CISE_OP_TIMER0_MODE_REGISTER_LD |=> !file_we && acc == $past(acc);
    endproperty
    a_timer0_mode_register_acc: assert property (p_timer0_mode_register_acc) else $error("mode load moved acc"); // RULE_06

    property p_timer0_mode_read;
        @(posedge sys_clk) disable iff (sys_rst)
        go && instr.op == CISE_OP_TIMER0_MODE_REGISTER_RD |=> acc == $past(timer0_mode_register);
    endproperty
    a_timer0_mode_read: assert property (p_timer0_mode_read) else $error("mode read wrong"); // RULE_07

    property p_timer0_mode_read_flags;
        @(posedge sys_clk) disable iff (sys_rst)
        go && instr.op == CISE_OP_TIMER0_MODE_REGISTER_RD |=> flags == $past(flags_in) && !file_we
            && timer0_mode_register == $past(timer0_mode_register);
    endproperty
    a_timer0_mode_read_flags: assert property (p_timer0_mode_read_flags) else $error("mode read side effect"); // RULE_07

    // a low enable must leave every register where it was, busy cycle included
    property p_freeze;
        @(posedge sys_clk) disable iff (sys_rst)
        !clk_en |=> acc == $past(acc) && flags == $past(flags) && busy == $past(busy)
            && file_we == $past(file_we) && timer0_mode_register == $past(timer0_mode_register);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule

// *** core/cise_defs.svh ***
// constants for the instruction subset execution block
// assumes inclusion by the package and the core file only
`ifndef CISE_DEFS_SVH
`define CISE_DEFS_SVH
`define CISE_FADDR_W 6
`define CISE_ROM_W 14
`define CISE_ROM_ADDR_W 11
`define CISE_HALF_LO 3
`define CISE_NIB_HI_LO 4
`define CISE_BYTE_HI 7
`define CISE_TABLE_HIGH_POINTER_LO 2
`define CISE_TABLE_HIGH_DATA_HI 5
`define CISE_ROM_HI 13
`define CISE_ROM_LO_HI 7
`define CISE_ACC_RST 8'h00
`define CISE_TIMER0_MODE_REGISTER_RST 8'h00
`define CISE_TABLE_HIGH_DATA_RST 6'h00
`define CISE_ZERO8 8'h00
`define CISE_SYNC_DEPTH 3
`endif

// *** core/cise_pkg.sv ***
// types for the instruction subset execution block
// assumes cise_defs.svh is on the include path
`include "cise_defs.svh"
package cise_pkg;
    typedef enum logic [3:0] {
        CISE_OP_NOP = 4'h0,
        CISE_OP_SUB_FILE = 4'h1,
        CISE_OP_SWAP = 4'h2,
        CISE_OP_SUB_IMM = 4'h3,
        CISE_OP_TABLE = 4'h4,
        CISE_OP_TIMER0_MODE_REGISTER_LD = 4'h5,
        CISE_OP_TIMER0_MODE_REGISTER_RD = 4'h6,
        CISE_OP_XOR_FILE = 4'h7,
        CISE_OP_XOR_IMM = 4'h8
    } cise_op_t;
    typedef struct packed {
        cise_op_t op;
        logic dest_sel;
        logic [`CISE_FADDR_W-1:0] faddr;
        logic [7:0] operand;
    } cise_instr_t;
    typedef struct packed {
        logic zero;
        logic half_carry_flag;
        logic carry;
    } cise_flags_t;
    typedef enum logic [0:0] {
        CISE_ST_IDLE = 1'b0,
        CISE_ST_TABLE = 1'b1
    } cise_state_t;
endpackage

// *** tb/test_cpu_instruction_subset_exec.sv ***
// self-checking bench for the instruction subset execution core
// assumes cise_pkg and cise_defs.svh are compiled first
`timescale 1ns/1ps
module test_cpu_instruction_subset_exec;
import cise_pkg::*;
logic sys_clk = 1'b0;
logic sys_rst = 1'b1;
logic clk_en = 1'b1;
logic instr_valid = 1'b0;
cise_instr_t instr = '0;
logic [7:0] file_rdata = 8'h00;
logic [2:0] table_high_pointer = 3'h0;
logic [13:0] rom_rdata = 14'h0a55;
cise_flags_t flags_in = 3'b011;
logic [7:0] acc, timer0_mode_register, file_wdata;
logic [5:0] table_high_data, file_waddr;
cise_flags_t flags;
logic [10:0] rom_addr;
logic rom_rd, file_we, busy;
logic [7:0] m_acc = 8'h00;
logic [7:0] m_mode = 8'h00;
int n_mismatch = 0;
int total_checks = 0;
int cyc = 0;
cise_core u_cise_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .table_high_pointer(table_high_pointer), .rom_rdata(rom_rdata),
    .flags_in(flags_in), .acc(acc), .timer0_mode_register(timer0_mode_register),
    .table_high_data(table_high_data), .flags(flags), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .busy(busy));
always #12.5 sys_clk = ~sys_clk;
// a hang is cut short far beyond the few dozen cycles the tests need
always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
        n_mismatch++;
        tally_and_finish();
    end
end
// ----------------------------------------
// checking and access tasks
// ----------------------------------------
task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("Error %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
// file operand address rides in the low six bits of the operand byte
task automatic run(input cise_op_t op, input logic d, input logic [7:0] opd, input logic [7:0] fr);
    logic [7:0] a, r;
    logic wf;
    cise_flags_t ef;
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr <= '{op, d, opd[5:0], opd};
    file_rdata <= fr;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    file_rdata <= ~fr;
    #1;
    a = (op == CISE_OP_SUB_IMM || op == CISE_OP_XOR_IMM) ? opd : fr;
    wf = d && (op == CISE_OP_SUB_FILE || op == CISE_OP_SWAP || op == CISE_OP_XOR_FILE);
    ef = flags_in;
    case (op)
        CISE_OP_SUB_FILE, CISE_OP_SUB_IMM: begin
            r = a - m_acc;
            ef = {r == 8'h00, a[3:0] >= m_acc[3:0], a >= m_acc};
        end
        CISE_OP_SWAP: r = {a[3:0], a[7:4]};
        CISE_OP_XOR_FILE, CISE_OP_XOR_IMM: begin
            r = a ^ m_acc;
            ef.zero = r == 8'h00;
        end
        default: r = (op == CISE_OP_TIMER0_MODE_REGISTER_LD) ? m_acc : m_mode;
    endcase
    if (op == CISE_OP_TIMER0_MODE_REGISTER_LD) m_mode = r;
    if (!wf) m_acc = r;
    chk("acc", m_acc, acc);
    chk("flags", {5'h00, ef}, {5'h00, flags});
    chk("mode", m_mode, timer0_mode_register);
    chk("file_we", {7'h00, wf}, {7'h00, file_we});
    if (wf) begin
        chk("file_wdata", r, file_wdata);
        chk("file_waddr", {2'h0, opd[5:0]}, {2'h0, file_waddr});
    end
    $display("%s done", op.name());
endtask
task automatic table_read(input logic [2:0] p, input logic [13:0] w);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr <= '{CISE_OP_TABLE, 1'b0, 6'h00, 8'h00};
    table_high_pointer <= p;
    @(posedge sys_clk);
    instr <= '{CISE_OP_XOR_IMM, 1'b0, 6'h00, 8'hff};
    rom_rdata <= w;
    #1;
    chk("rom_rd", 8'h01, {7'h00, rom_rd});
    chk("busy", 8'h01, {7'h00, busy});
    chk("rom_addr_hi", {5'h00, p}, {5'h00, rom_addr[10:8]});
    chk("rom_addr_lo", m_acc, rom_addr[7:0]);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    rom_rdata <= ~w;
    table_high_pointer <= ~p;
    #1;
    m_acc = w[7:0];
    chk("acc", m_acc, acc);
    chk("table_high_data", {2'h0, w[13:8]}, {2'h0, table_high_data});
    chk("busy", 8'h00, {7'h00, busy});
    chk("rom_rd", 8'h00, {7'h00, rom_rd});
    chk("flags", {5'h00, flags_in}, {5'h00, flags});
    $display("table read done");
endtask
// ----------------------------------------
// test sequence
// ----------------------------------------
initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk("acc", 8'h00, acc);
    chk("mode", 8'h00, timer0_mode_register);
    chk("table_high_data", 8'h00, {2'h0, table_high_data});
    $display("reset test done");
    run(CISE_OP_XOR_IMM, 1'b0, 8'hf0, 8'h00);
    run(CISE_OP_XOR_IMM, 1'b0, 8'hf0, 8'h00);
    run(CISE_OP_XOR_IMM, 1'b0, 8'h06, 8'h00);
    run(CISE_OP_SUB_IMM, 1'b0, 8'h05, 8'h00);
    run(CISE_OP_SUB_IMM, 1'b0, 8'hff, 8'h00);
    run(CISE_OP_SUB_FILE, 1'b1, 8'h3f, 8'h05);
    run(CISE_OP_XOR_IMM, 1'b0, 8'h12, 8'h00);
    run(CISE_OP_SUB_FILE, 1'b0, 8'h00, 8'h21);
    run(CISE_OP_SUB_FILE, 1'b1, 8'h01, 8'h05);
    @(posedge sys_clk) flags_in <= 3'b100;
    run(CISE_OP_SWAP, 1'b1, 8'h20, 8'ha5);
    run(CISE_OP_SWAP, 1'b0, 8'h00, 8'ha5);
    run(CISE_OP_XOR_FILE, 1'b1, 8'h3f, 8'ha5);
    run(CISE_OP_XOR_FILE, 1'b0, 8'h00, 8'h5a);
    run(CISE_OP_XOR_IMM, 1'b0, 8'haa, 8'h00);
    run(CISE_OP_TIMER0_MODE_REGISTER_LD, 1'b0, 8'h00, 8'h00);
    run(CISE_OP_XOR_IMM, 1'b0, 8'h55, 8'h00);
    run(CISE_OP_TIMER0_MODE_REGISTER_RD, 1'b0, 8'h00, 8'h00);
    run(CISE_OP_XOR_IMM, 1'b0, 8'h9e, 8'h00);
    table_read(3'h2, 14'h35aa);
    // a low enable must swallow an offered instruction without trace
    @(posedge sys_clk);
    clk_en <= 1'b0;
    instr_valid <= 1'b1;
    instr <= '{CISE_OP_XOR_IMM, 1'b0, 6'h00, 8'hff};
    repeat (2) @(posedge sys_clk);
    clk_en <= 1'b1;
    instr_valid <= 1'b0;
    #1;
    chk("acc", m_acc, acc);
    chk("flags", {5'h00, flags_in}, {5'h00, flags});
    chk("file_we", 8'h00, {7'h00, file_we});
    $display("clock enable test done");
    tally_and_finish();
end
endmodule
